// ---- src/slc_pkg.sv ----
// Constants, register map and carrier types for the second-level cache timing control.
// Assumes a single core clock domain and a byte-wide register port.
`default_nettype none
package slc_pkg;
  localparam logic [7:0] SLC_CTRL_OFS = 8'hD0;
  localparam logic [7:0] SLC_STAT_OFS = 8'hD1;
  localparam logic [7:0] SLC_CTRL_RST = 8'h00;
  localparam int SLC_FIRST_RD_BIT = 0;
  localparam int SLC_BURST_RD_BIT = 1;
  localparam int SLC_WR_NOWS_BIT = 2;
  localparam int SLC_SIZE_LSB = 3;
  localparam int SLC_ENGAGE_BIT = 5;
  localparam int SLC_SUSP_DRIVE_BIT = 6;
  localparam int SLC_CS_GAP_BIT = 7;
  localparam logic [1:0] SLC_SIZE_RSVD = 2'h3;
  localparam logic [1:0] SLC_FIRST_SLOW = 2'h3;
  localparam logic [1:0] SLC_FIRST_FAST = 2'h2;
  localparam logic [1:0] SLC_BURST_SLOW = 2'h2;
  localparam logic [1:0] SLC_BURST_FAST = 2'h1;
  localparam logic [1:0] SLC_WR_BASE = 2'h1;
  localparam logic [1:0] SLC_LAST_BEAT = 2'h3;
  localparam logic [1:0] SLC_STRAP_WAIT = 2'h2;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } slc_bus_req_t;

  typedef enum logic [1:0] {
    SLC_IDLE = 2'h0,
    SLC_FIRST = 2'h1,
    SLC_BURST = 2'h3,
    SLC_WRITE = 2'h2
  } slc_state_t;
endpackage
`default_nettype wire

// ---- src/slc_timing_ctrl.sv ----
// Second-level cache control register and cache cycle sequencer with SRAM select pins.
// Assumes requests come from logic on core_clk; straps and power-state inputs are asynchronous pins.
//
// The implementer's own choice: the strobed register port.
`default_nettype none
module slc_timing_ctrl (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire slc_pkg::slc_bus_req_t bus_req,
  output logic [7:0] rd_data,
  input wire logic cyc_req,
  input wire logic cyc_write,
  output logic cyc_busy,
  output logic xfer_ack,
  output logic cyc_done,
  input wire logic cache_strap,
  input wire logic suspend_pin,
  input wire logic stop_grant_pin,
  output logic [3:0] cache_chip_selects_n,
  output logic cache_chip_selects_oe,
  output logic shared_pin_out,
  output logic shared_pin_oe,
  output logic [1:0] cache_size,
  output logic cache_active,
  output logic cache_if_enabled
);
  logic [1:0] rst_q;
  logic rst_n;
  logic [2:0] pin_q1;
  logic [2:0] pin_q2;
  logic strap_s;
  logic susp_s;
  logic sg_s;
  logic strap_taken;
  logic [1:0] strap_wait;
  logic [7:0] ctrl;
  slc_pkg::slc_state_t state;
  logic [1:0] cnt;
  logic [1:0] beat;
  logic burst_slow;
  logic compat_clk;
  logic start;
  logic ctl_drive;
  logic [1:0] first_len;
  logic [1:0] burst_len;
  logic [1:0] wr_len;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_q1 <= 3'h0;
      pin_q2 <= 3'h0;
    end else begin
      pin_q1 <= {cache_strap, suspend_pin, stop_grant_pin};
      pin_q2 <= pin_q1;
    end
  end
  assign strap_s = pin_q2[2];
  assign susp_s = pin_q2[1];
  assign sg_s = pin_q2[0];

  // strap capture once
  // The synchroniser leaves reset empty, so the strap is caught only once both stages hold the pin.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_wait <= 2'h0;
      strap_taken <= 1'b0;
      cache_if_enabled <= 1'b0;
    end else if (!strap_taken) begin
      if (strap_wait == slc_pkg::SLC_STRAP_WAIT) begin
        strap_taken <= 1'b1;
        cache_if_enabled <= !strap_s;
      end else begin
        strap_wait <= strap_wait + 2'h1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= slc_pkg::SLC_CTRL_RST;
    end else if (bus_req.wr && bus_req.addr == slc_pkg::SLC_CTRL_OFS) begin
      ctrl <= bus_req.wdata;
    end
  end

  // Unmapped offsets read as zero so probing software sees no phantom registers.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
    end else if (bus_req.rd && bus_req.addr == slc_pkg::SLC_CTRL_OFS) begin
      rd_data <= ctrl;
    end else if (bus_req.rd && bus_req.addr == slc_pkg::SLC_STAT_OFS) begin
      rd_data <= {3'h0, sg_s, susp_s, cyc_busy, cache_active, cache_if_enabled};
    end else begin
      rd_data <= 8'h00;
    end
  end

  assign first_len = ctrl[slc_pkg::SLC_FIRST_RD_BIT] ? slc_pkg::SLC_FIRST_FAST : slc_pkg::SLC_FIRST_SLOW;
  assign burst_len = burst_slow ? slc_pkg::SLC_BURST_SLOW : slc_pkg::SLC_BURST_FAST;
  assign wr_len = ctrl[slc_pkg::SLC_WR_NOWS_BIT] ? slc_pkg::SLC_WR_BASE : slc_pkg::SLC_WR_BASE + 2'h1;
  assign start = cyc_req && cache_active && state == slc_pkg::SLC_IDLE;
  assign ctl_drive = !susp_s || ctrl[slc_pkg::SLC_SUSP_DRIVE_BIT];

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cache_active <= 1'b0;
      cache_size <= 2'h0;
    end else begin
      cache_size <= ctrl[slc_pkg::SLC_SIZE_LSB +: 2];
      cache_active <= cache_if_enabled && ctrl[slc_pkg::SLC_ENGAGE_BIT] && !susp_s && !sg_s
                      && ctrl[slc_pkg::SLC_SIZE_LSB +: 2] != slc_pkg::SLC_SIZE_RSVD;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= slc_pkg::SLC_IDLE;
      cnt <= 2'h0;
      beat <= 2'h0;
      burst_slow <= 1'b0;
      xfer_ack <= 1'b0;
      cyc_done <= 1'b0;
    end else begin
      xfer_ack <= 1'b0;
      cyc_done <= 1'b0;
      case (state)
        slc_pkg::SLC_IDLE: begin
          if (start) begin
            state <= cyc_write ? slc_pkg::SLC_WRITE : slc_pkg::SLC_FIRST;
            cnt <= (cyc_write ? wr_len : first_len) - 2'h1;
            beat <= 2'h0;
            burst_slow <= ctrl[slc_pkg::SLC_BURST_RD_BIT];
          end
        end
        slc_pkg::SLC_FIRST, slc_pkg::SLC_BURST: begin
          if (cnt == 2'h0) begin
            xfer_ack <= 1'b1;
            if (beat == slc_pkg::SLC_LAST_BEAT) begin
              state <= slc_pkg::SLC_IDLE;
              cyc_done <= 1'b1;
            end else begin
              state <= slc_pkg::SLC_BURST;
              beat <= beat + 2'h1;
              cnt <= burst_len - 2'h1;
            end
          end else begin
            cnt <= cnt - 2'h1;
          end
        end
        default: begin
          if (cnt == 2'h0) begin
            xfer_ack <= 1'b1;
            cyc_done <= 1'b1;
            state <= slc_pkg::SLC_IDLE;
          end else begin
            cnt <= cnt - 2'h1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc_busy <= 1'b0;
      compat_clk <= 1'b0;
      cache_chip_selects_n <= 4'hF;
      cache_chip_selects_oe <= 1'b0;
      shared_pin_out <= 1'b1;
      shared_pin_oe <= 1'b0;
    end else begin
      cyc_busy <= start || (state != slc_pkg::SLC_IDLE && !cyc_done);
      compat_clk <= !compat_clk;
      cache_chip_selects_oe <= ctl_drive;
      if (cache_active && (state != slc_pkg::SLC_IDLE || !ctrl[slc_pkg::SLC_CS_GAP_BIT])) begin
        cache_chip_selects_n <= 4'h0;
      end else begin
        cache_chip_selects_n <= 4'hF;
      end
      shared_pin_out <= cache_if_enabled ? (state == slc_pkg::SLC_IDLE) : compat_clk;
      // The pin floats until the strap names its function, so no stray edge reaches the tag RAM.
      shared_pin_oe <= strap_taken && (cache_if_enabled ? ctl_drive : 1'b1);
    end
  end

  sequence s_fast_burst;
    xfer_ack ##1 xfer_ack ##1 xfer_ack ##1 xfer_ack;
  endsequence

  property p_first_slow;
    @(posedge core_clk) disable iff (!rst_n)
      start && !cyc_write && !ctrl[0] |=> !xfer_ack [*3] ##1 xfer_ack;
  endproperty
  a_first_slow: assert property (p_first_slow) else $error("Slow first read not three clocks.");

  property p_burst_slow;
    @(posedge core_clk) disable iff (!rst_n)
      xfer_ack && state == slc_pkg::SLC_BURST && burst_slow |=> !xfer_ack ##1 xfer_ack;
  endproperty
  a_burst_slow: assert property (p_burst_slow) else $error("Slow burst beat not two clocks.");

  property p_write_ws;
    @(posedge core_clk) disable iff (!rst_n)
      start && cyc_write && !ctrl[2] |=> !xfer_ack [*2] ##1 (xfer_ack && cyc_done);
  endproperty
  a_write_ws: assert property (p_write_ws) else $error("Write wait state missing.");

  property p_size_rsvd;
    @(posedge core_clk) disable iff (!rst_n)
      ctrl[4:3] == slc_pkg::SLC_SIZE_RSVD |=> !cache_active;
  endproperty
  a_size_rsvd: assert property (p_size_rsvd) else $error("Reserved size left cache active.");

  property p_disengaged;
    @(posedge core_clk) disable iff (!rst_n)
      !cache_active && state == slc_pkg::SLC_IDLE |=> state == slc_pkg::SLC_IDLE;
  endproperty
  a_disengaged: assert property (p_disengaged) else $error("Cycle started while disengaged.");

  property p_susp_float;
    @(posedge core_clk) disable iff (!rst_n)
      susp_s && !ctrl[6] |=> !cache_chip_selects_oe;
  endproperty
  a_susp_float: assert property (p_susp_float) else $error("Controls driven in suspend.");

  property p_cs_gap;
    @(posedge core_clk) disable iff (!rst_n)
      ctrl[7] && state == slc_pkg::SLC_IDLE |=> cache_chip_selects_n == 4'hF;
  endproperty
  a_cs_gap: assert property (p_cs_gap) else $error("Chip selects held between accesses.");

  property p_fast_burst;
    @(posedge core_clk) disable iff (!rst_n)
      start && !cyc_write && ctrl[0] && !ctrl[1] |=> !xfer_ack [*2] ##1 s_fast_burst;
  endproperty
  a_fast_burst: assert property (p_fast_burst) else $error("Fast burst not two one one one.");

  property p_strap;
    @(posedge core_clk) disable iff (!rst_n)
      !strap_taken && strap_wait == slc_pkg::SLC_STRAP_WAIT |=> cache_if_enabled == !$past(strap_s);
  endproperty
  a_strap: assert property (p_strap) else $error("Strap result not captured.");

  property p_tag_pin;
    @(posedge core_clk) disable iff (!rst_n)
      cache_if_enabled && state != slc_pkg::SLC_IDLE |=> !shared_pin_out;
  endproperty
  a_tag_pin: assert property (p_tag_pin) else $error("Shared pin not carrying tag select.");
endmodule
`default_nettype wire

// ---- test/slc_sram_model.sv ----
// External cache SRAM stand-in that counts tag lookups on the shared pin.
// Assumes a pull-up holds the tag select high whenever the pin is not driven.
`default_nettype none
module slc_sram_model (
  input wire logic core_clk,
  input wire logic tag_pin,
  input wire logic tag_oe,
  output int lookups
);
  timeunit 1ns;
  timeprecision 1ps;
  logic prev = 1'b1;
  int count = 0;
  wire logic level = tag_oe ? tag_pin : 1'b1;
  assign lookups = count;
  always @(posedge core_clk) begin
    if (prev && !level) count <= count + 1;
    prev <= level;
  end
endmodule
`default_nettype wire

// ---- test/slc_timing_ctrl_test.sv ----
// Self-checking bench for the cache timing control: register port, cache cycles and pins.
// Assumes the SRAM model only observes; the bench plays the register master and requester.
`default_nettype none
module slc_timing_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] ctrl; logic wr; int first; int gap; int n;} slc_row_t;
  slc_row_t rows [6] = '{'{8'h20, 0, 4, 1, 4}, '{8'h21, 0, 3, 1, 4}, '{8'h23, 0, 3, 2, 4},
    '{8'h22, 0, 4, 2, 4}, '{8'h20, 1, 3, 0, 1}, '{8'h24, 1, 2, 0, 1}};
  logic core_clk = 0, rst_b = 0, cyc_req = 0, cyc_write = 0;
  logic cache_strap = 0, suspend_pin = 0, stop_grant_pin = 0;
  slc_pkg::slc_bus_req_t bus_req = '0;
  logic [7:0] rd_data;
  logic cyc_busy, xfer_ack, cyc_done, cs_oe, shared_pin_out, shared_pin_oe, cache_active, cache_if_enabled;
  logic [3:0] cs_n;
  logic [1:0] cache_size;
  int mismatches = 0, checks = 0, lookups;
  always #2.5 core_clk = ~core_clk;
  slc_timing_ctrl DUT (.core_clk(core_clk), .rst_b(rst_b), .bus_req(bus_req), .rd_data(rd_data),
    .cyc_req(cyc_req), .cyc_write(cyc_write), .cyc_busy(cyc_busy), .xfer_ack(xfer_ack),
    .cyc_done(cyc_done), .cache_strap(cache_strap), .suspend_pin(suspend_pin),
    .stop_grant_pin(stop_grant_pin), .cache_chip_selects_n(cs_n), .cache_chip_selects_oe(cs_oe),
    .shared_pin_out(shared_pin_out), .shared_pin_oe(shared_pin_oe), .cache_size(cache_size),
    .cache_active(cache_active), .cache_if_enabled(cache_if_enabled));
  slc_sram_model sram (.core_clk(core_clk), .tag_pin(shared_pin_out), .tag_oe(shared_pin_oe),
    .lookups(lookups));
  task test_done;
    if (mismatches == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task idle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk) bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk) bus_req <= '0;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk) bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk) bus_req <= '0;
    #1 d = rd_data;
  endtask
  task do_reset(input logic strap);
    rst_b <= 1'b0;
    cache_strap <= strap;
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
    idle(8);
  endtask
  task pulse_req(input logic w);
    @(posedge core_clk) begin
      cyc_req <= 1'b1;
      cyc_write <= w;
    end
    @(posedge core_clk) cyc_req <= 1'b0;
  endtask
  initial begin
    #100us;
    mismatches++;
    test_done();
  end
  initial begin
    logic [7:0] d;
    logic [15:0] exp, seen, done_seen;
    do_reset(1'b0);
    rd(slc_pkg::SLC_CTRL_OFS, d);
    check(d, slc_pkg::SLC_CTRL_RST);
    rd(slc_pkg::SLC_STAT_OFS, d);
    check(d[0], 1'b1);
    wr(8'h55, 8'hFF);
    rd(8'h55, d);
    check(d, 8'h00);
    rd(slc_pkg::SLC_CTRL_OFS, d);
    check(d, 8'h00);
    for (int i = 0; i < 6; i++) begin
      wr(slc_pkg::SLC_CTRL_OFS, rows[i].ctrl & 8'hDF);
      wr(slc_pkg::SLC_CTRL_OFS, rows[i].ctrl);
      idle(2);
      check(cache_active, 1'b1);
      exp = '0;
      seen = '0;
      done_seen = '0;
      for (int b = 0; b < rows[i].n; b++) exp[rows[i].first + b * rows[i].gap] = 1'b1;
      pulse_req(rows[i].wr);
      for (int k = 1; k < 16; k++) begin
        #1 seen[k] = xfer_ack;
        done_seen[k] = cyc_done;
        if (k == 2) check({cs_n, shared_pin_out, cyc_busy}, 6'h01);
        @(posedge core_clk);
      end
      check(seen, exp);
      check(done_seen, 16'h1 << (rows[i].first + (rows[i].n - 1) * rows[i].gap));
    end
    check(16'(lookups), 16'h6);
    wr(slc_pkg::SLC_CTRL_OFS, 8'hA1);
    idle(3);
    check(cs_n, 4'hF);
    wr(slc_pkg::SLC_CTRL_OFS, 8'h21);
    idle(3);
    check(cs_n, 4'h0);
    for (int s = 0; s < 4; s++) begin
      wr(slc_pkg::SLC_CTRL_OFS, 8'h20 | 8'(s << 3));
      idle(3);
      check({cache_size, cache_active}, {2'(s), s != 3});
    end
    wr(slc_pkg::SLC_CTRL_OFS, 8'h01);
    idle(3);
    pulse_req(1'b0);
    #1 check({cache_active, cyc_busy}, 2'h0);
    idle(3);
    check({cyc_busy, xfer_ack}, 2'h0);
    wr(slc_pkg::SLC_CTRL_OFS, 8'h20);
    @(posedge core_clk) suspend_pin <= 1'b1;
    idle(5);
    check({cs_oe, cache_active}, 2'h0);
    wr(slc_pkg::SLC_CTRL_OFS, 8'h60);
    idle(3);
    check(cs_oe, 1'b1);
    @(posedge core_clk) suspend_pin <= 1'b0;
    idle(5);
    check({cs_n, cache_active}, 5'h01);
    @(posedge core_clk) stop_grant_pin <= 1'b1;
    idle(5);
    check(cs_n, 4'hF);
    @(posedge core_clk) stop_grant_pin <= 1'b0;
    do_reset(1'b1);
    check({cache_if_enabled, shared_pin_oe}, 2'h1);
    rd(slc_pkg::SLC_STAT_OFS, d);
    check(d[0], 1'b0);
    test_done();
  end
endmodule
`default_nettype wire
